// *** src/ddr_burst2_ctrl.sv ***
`timescale 1ns/1ps
// plain first-in first-out buffer; full is registered for a clean ready
module word_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign next_cnt = (push & ~pop) ? cnt + 1'b1 : ((pop & ~push) ? cnt - 1'b1 : cnt);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt <= next_cnt;
      in_ready <= next_cnt != (AW+1)'(DEPTH);
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule : word_fifo

// controller end: makes the link clocks, issues queued writes and single reads
module ddr_burst2_ctrl
  import ddr_b2_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire wr_req_t wr_req,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire addr_t rd_addr,
  output logic rdata_valid,
  output data_t rdata0,
  output data_t rdata1,
  input wire logic out_clk_tie,
  input wire logic dll_bypass,
  ddr_b2_link_if.ctrl link
);
  logic f_valid;
  wr_req_t f_req;
  logic [2:0] div;
  logic kq, kn, ct, cc, prep_rise, prep_fall;
  assign prep_rise = (div == 3'(`K_HALF_CYC - 2)) & ~kq;
  assign prep_fall = (div == 3'(`K_HALF_CYC - 2)) & kq;

  // write requests queue here; popped one per clock period
  word_fifo #(.W($bits(wr_req_t)), .DEPTH(`FIFO_DEPTH)) wq_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_req),
    .out_valid(f_valid),
    .out_ready(prep_rise),
    .out_data(f_req)
  );

  addr_t rq_addr, a;
  wr_req_t wcur;
  logic wact, rsel_n, wsel_n, dll_off;
  data_t wd;
  lanes_t bw_n;

  // pins change one clk before the clock edge that samples them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div <= 3'h0;
      kq <= 1'b0;
      kn <= 1'b1;
      ct <= 1'b0;
      cc <= 1'b1;
      rsel_n <= 1'b1;
      wsel_n <= 1'b1;
      wact <= 1'b0;
      rd_ready <= 1'b1;
      dll_off <= 1'b1;
      a <= '0;
      wd <= '0;
      bw_n <= '1;
    end else begin
      dll_off <= ~dll_bypass;
      div <= (div == 3'(`K_HALF_CYC - 1)) ? 3'h0 : div + 3'h1;
      if (div == 3'(`K_HALF_CYC - 1)) begin
        kq <= ~kq;
        kn <= kq;
        ct <= out_clk_tie | ~kq; // tie holds both output clocks high
        cc <= out_clk_tie | kq;
      end
      if (rd_valid & rd_ready) begin
        rd_ready <= 1'b0;
      end
      if (prep_rise) begin
        rsel_n <= rd_ready;
        wsel_n <= ~f_valid;
        if (!rd_ready) begin
          a <= rq_addr;
          rd_ready <= 1'b1;
        end
        if (f_valid) begin
          wd <= f_req.d0;
          bw_n <= f_req.bw0_n;
          wact <= 1'b1;
        end
      end
      if (prep_fall) begin
        rsel_n <= 1'b1;
        wsel_n <= 1'b1;
        if (wact) begin
          a <= wcur.addr;
          wd <= wcur.d1;
          bw_n <= wcur.bw1_n;
          wact <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rd_valid & rd_ready) rq_addr <= rd_addr;
    if (prep_rise & f_valid) wcur <= f_req;
  end

  assign link.k = kq;
  assign link.k_n = kn;
  assign link.c = ct;
  assign link.c_n = cc;
  assign link.sync_addr = a;
  assign link.rd_sel_n = rsel_n;
  assign link.wr_sel_n = wsel_n;
  assign {link.byte_write_lane3_n, link.byte_write_lane2_n,
          link.byte_write_lane1_n, link.byte_write_lane0_n} = bw_n;
  assign link.write_data_bus = wd;
  assign link.dll_off_n = dll_off;

  // read return: echo and data pass the same two stages, so they stay aligned
  logic [`DATA_W+1:0] e1, e2;
  logic [1:0] e3;
  logic ev, issue, rptr;
  data_t qd;
  assign qd = e2[`DATA_W-1:0];
  assign ev = (e2[`DATA_W+1] & ~e3[1]) | (e2[`DATA_W] & ~e3[0]);
  assign issue = prep_rise & ~rd_ready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      e1 <= '0;
      e2 <= '0;
      e3 <= '0;
      rptr <= 1'b0;
    end else begin
      e1 <= {link.echo_clk_true, link.echo_clk_comp, link.read_data_bus};
      e2 <= e1;
      e3 <= e2[`DATA_W+1 -: 2];
      if (issue) rptr <= ~rptr;
    end
  end

  logic [1:0] g0, g1;
  genvar j;
  generate
    for (j = 0; j < 2; j++) begin : slot
      logic v, byp;
      logic [2:0] cnt, nc, first;
      assign nc = cnt + 3'h1;
      assign first = byp ? 3'(`RD_FIRST_BYP + `ECHO_SKEW) : 3'(`RD_FIRST_DLL + `ECHO_SKEW);
      assign g0[j] = ev & v & (nc == first);
      assign g1[j] = ev & v & (nc == first + 3'h1);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          v <= 1'b0;
          byp <= 1'b0;
          cnt <= 3'h0;
        end else if (issue & (rptr == 1'(j))) begin
          v <= 1'b1;
          byp <= dll_bypass;
          cnt <= 3'h0;
        end else if (ev & v) begin
          cnt <= nc;
          if (g1[j]) v <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_valid <= 1'b0;
      rdata0 <= '0;
      rdata1 <= '0;
    end else begin
      rdata_valid <= |g1;
      if (|g0) rdata0 <= qd;
      if (|g1) rdata1 <= qd;
    end
  end
endmodule : ddr_burst2_ctrl

// *** common/ddr_b2_regs.svh ***
`ifndef DDR_B2_REGS_SVH
`define DDR_B2_REGS_SVH
// organisation 512K words x 36: 256K burst addresses, four 9-bit lanes
// the other organisation (1M x 18) is ADDR_W 19, DATA_W 18, LANES 2
`define ADDR_W 18
`define DATA_W 36
`define LANES 4
`define LANE_W 9
// timing of the link clock made by the controller end
`define CLK_PERIOD_NS 50
`define K_PERIOD_NS 400
`define K_HALF_CYC (`K_PERIOD_NS / `CLK_PERIOD_NS / 2)
// output clock edge index of the first read beat; command edge is index 1
`define RD_FIRST_DLL 4
`define RD_FIRST_BYP 3
// extra echo edge the controller sees before the command's own edge
`define ECHO_SKEW 1
`define FIFO_DEPTH 16
`endif

// *** common/ddr_b2_pkg.sv ***
package ddr_b2_pkg;
`include "ddr_b2_regs.svh"
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`LANES-1:0] lanes_t;
  typedef struct packed {
    addr_t addr;
    data_t d0;
    data_t d1;
    lanes_t bw0_n;
    lanes_t bw1_n;
  } wr_req_t;
endpackage : ddr_b2_pkg

// *** common/ddr_b2_link_if.sv ***
`timescale 1ns/1ps
interface ddr_b2_link_if;
  import ddr_b2_pkg::*;
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  addr_t sync_addr;
  logic rd_sel_n;
  logic wr_sel_n;
  logic byte_write_lane0_n;
  logic byte_write_lane1_n;
  logic byte_write_lane2_n;
  logic byte_write_lane3_n;
  data_t write_data_bus;
  logic dll_off_n;
  data_t read_data_bus;
  logic echo_clk_true;
  logic echo_clk_comp;
  modport mem (
    input k, k_n, c, c_n, sync_addr, rd_sel_n, wr_sel_n,
    input byte_write_lane0_n, byte_write_lane1_n,
    input byte_write_lane2_n, byte_write_lane3_n,
    input write_data_bus, dll_off_n,
    output read_data_bus, echo_clk_true, echo_clk_comp
  );
  modport ctrl (
    output k, k_n, c, c_n, sync_addr, rd_sel_n, wr_sel_n,
    output byte_write_lane0_n, byte_write_lane1_n,
    output byte_write_lane2_n, byte_write_lane3_n,
    output write_data_bus, dll_off_n,
    input read_data_bus, echo_clk_true, echo_clk_comp
  );
endinterface : ddr_b2_link_if

// *** src/ddr_burst2_sram.sv ***
`timescale 1ns/1ps
// What this block does
// - separate read and write ports, concurrent
// - every access is two beats
// - true clock rise: read addr, selects, beat0
// - comp clock rise: write addr, beat1
// - byte selects gate their lane per beat
// - early write data held in buffer
// - controller gives beat0 with command, beat1 next
// - first read beat 1.5 cycles after command
// - second read beat two cycles after command
// - output clocks both high: time from input clocks
// - echo clock pair follows read beats
// - operations start on true input clock rise
// - organised 512Kx36 or 1Mx18
// - write select low starts write cycle
// - dll off gives one cycle read latency
// - address ignored while not selected
module ddr_burst2_sram
  import ddr_b2_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ddr_b2_link_if.mem link,
  output logic wr_commit
);
  localparam int SW = 7 + `LANES + `ADDR_W + `DATA_W;
  localparam int MW = `ADDR_W + 1;
  localparam int LW = `LANE_W;

  // two-stage synchroniser for every link input; a third stage on the clocks only
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [3:0] clk3;

  // reset to ones: selects idle and no false clock edge after release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      clk3 <= '1;
    end else begin
      s1 <= {link.k, link.k_n, link.c, link.c_n, link.rd_sel_n, link.wr_sel_n,
             link.dll_off_n, link.byte_write_lane3_n, link.byte_write_lane2_n,
             link.byte_write_lane1_n, link.byte_write_lane0_n,
             link.sync_addr, link.write_data_bus};
      s2 <= s1;
      clk3 <= s2[SW-1 -: 4];
    end
  end

  logic k2, kn2, c2, cn2, rd_n, wr_n, dll_n;
  logic k3, kn3, c3, cn3;
  lanes_t bw_n;
  addr_t addr;
  data_t wd;
  assign {k2, kn2, c2, cn2, rd_n, wr_n, dll_n, bw_n, addr, wd} = s2;
  assign {k3, kn3, c3, cn3} = clk3;

  // edge detection on the synchronised clocks
  logic k_rise, kn_rise, c_tied, t_rise, c_rise, ev;
  assign k_rise = k2 & ~k3;
  assign kn_rise = kn2 & ~kn3;
  // tie judged one stage late, so the edge that releases a tie is still timed
  assign c_tied = c3 & cn3;
  assign t_rise = c_tied ? k_rise : (c2 & ~c3);
  assign c_rise = c_tied ? kn_rise : (cn2 & ~cn3);
  assign ev = t_rise | c_rise;

  // array: two words per burst address, index lsb is the beat
  data_t mem [0:(1 << MW) - 1];

  // early data waits here until its address arrives half a cycle later
  data_t early_d;
  lanes_t early_bw_n;
  logic early_open;
  // posted write buffer: retired into the array by the next write
  addr_t buf_addr;
  data_t buf_d0;
  data_t buf_d1;
  lanes_t buf_bw0_n;
  lanes_t buf_bw1_n;
  logic buf_valid;

  logic wr_start, wr_addr_in, do_commit, rd_cmd;
  assign wr_start = k_rise & ~wr_n;
  assign wr_addr_in = kn_rise & early_open;
  assign do_commit = wr_addr_in & buf_valid;
  assign rd_cmd = k_rise & ~rd_n;

  // stored words at the buffer address and at the read address
  data_t st0, st1, rs0, rs1, cm0, cm1, rm0, rm1;
  logic hit;
  assign st0 = mem[{buf_addr, 1'b0}];
  assign st1 = mem[{buf_addr, 1'b1}];
  assign rs0 = mem[{addr, 1'b0}];
  assign rs1 = mem[{addr, 1'b1}];
  assign hit = buf_valid & (buf_addr == addr);

  // per lane merge: commit keeps lanes whose select is high
  genvar i;
  generate
    for (i = 0; i < `LANES; i++) begin : lane
      assign cm0[i*LW +: LW] = buf_bw0_n[i] ? st0[i*LW +: LW] : buf_d0[i*LW +: LW];
      assign cm1[i*LW +: LW] = buf_bw1_n[i] ? st1[i*LW +: LW] : buf_d1[i*LW +: LW];
      assign rm0[i*LW +: LW] = (hit & ~buf_bw0_n[i]) ? buf_d0[i*LW +: LW]
                                                      : rs0[i*LW +: LW];
      assign rm1[i*LW +: LW] = (hit & ~buf_bw1_n[i]) ? buf_d1[i*LW +: LW]
                                                      : rs1[i*LW +: LW];
    end
  endgenerate

  // array write port; reads use the other port, so no turnaround
  always_ff @(posedge clk) begin
    if (do_commit) begin
      mem[{buf_addr, 1'b0}] <= cm0;
      mem[{buf_addr, 1'b1}] <= cm1;
    end
  end

  // write capture: beat0 on true rise, address and beat1 on comp rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      early_open <= 1'b0;
      buf_valid <= 1'b0;
      wr_commit <= 1'b0;
    end else begin
      wr_commit <= do_commit;
      if (wr_start) begin
        early_open <= 1'b1;
      end else if (wr_addr_in) begin
        early_open <= 1'b0;
        buf_valid <= 1'b1;
      end
    end
  end

  // buffer data carries no control meaning, so it needs no reset
  always_ff @(posedge clk) begin
    if (wr_start) begin
      early_d <= wd;
      early_bw_n <= bw_n;
    end
    if (wr_addr_in) begin
      buf_addr <= addr;
      buf_d0 <= early_d;
      buf_d1 <= wd;
      buf_bw0_n <= early_bw_n;
      buf_bw1_n <= bw_n;
    end
  end

  // two read slots: reads may come every cycle and each lives up to two cycles
  logic rptr;
  logic [1:0] f0;
  logic [1:0] f1;
  data_t b0 [2];
  data_t b1 [2];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rptr <= 1'b0;
    end else if (rd_cmd) begin
      rptr <= ~rptr;
    end
  end

  genvar j;
  generate
    for (j = 0; j < 2; j++) begin : slot
      logic v;
      logic byp;
      logic [2:0] cnt;
      logic [2:0] nc;
      logic [2:0] first;
      logic cap;
      data_t d0;
      data_t d1;
      assign cap = rd_cmd & (rptr == 1'(j));
      assign nc = cnt + 3'h1;
      assign first = byp ? 3'(`RD_FIRST_BYP) : 3'(`RD_FIRST_DLL);
      assign f0[j] = ev & v & (nc == first);
      assign f1[j] = ev & v & (nc == first + 3'h1);
      assign b0[j] = d0;
      assign b1[j] = d1;

      // the command's own edge counts as index 1; capture wins over retire
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          v <= 1'b0;
          byp <= 1'b0;
          cnt <= 3'h0;
        end else begin
          if (ev & v) begin
            cnt <= nc;
            if (f1[j]) begin
              v <= 1'b0;
            end
          end
          if (cap) begin
            v <= 1'b1;
            cnt <= 3'h1;
            byp <= ~dll_n;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (cap) begin
          d0 <= rm0;
          d1 <= rm1;
        end
      end
    end
  endgenerate

  // output register and echo clocks move on the same timing edges
  logic echo_t, echo_c;
  data_t q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      echo_t <= 1'b0;
      echo_c <= 1'b0;
      q <= '0;
    end else begin
      if (t_rise) begin
        echo_t <= 1'b1;
        echo_c <= 1'b0;
      end else if (c_rise) begin
        echo_t <= 1'b0;
        echo_c <= 1'b1;
      end
      if (|f0) begin
        q <= f0[0] ? b0[0] : b0[1];
      end else if (|f1) begin
        q <= f1[0] ? b1[0] : b1[1];
      end
    end
  end

  // q holds its last beat between bursts; echo runs free
  assign link.read_data_bus = q;
  assign link.echo_clk_true = echo_t;
  assign link.echo_clk_comp = echo_c;
endmodule : ddr_burst2_sram

// *** testbench/ddr_burst2_sram_port_assertions.sv ***
`timescale 1ns/1ps
module ddr_burst2_sram_port_assertions
  import ddr_b2_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire addr_t sync_addr,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic byte_write_lane0_n,
  input wire data_t write_data_bus,
  input wire data_t read_data_bus,
  input wire logic echo_clk_true,
  input wire logic echo_clk_comp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // the link clock pair and its fixed half period of four clk
  a_k_pair_comp: assert property (k_n == !k)
    else $error("k_n is not the complement of k");
  a_k_half_period: assert property ($changed(k) |=> $stable(k)[*3] ##1 $changed(k))
    else $error("k half period is not four cycles");
  // selects are set up one cycle ahead of the k rise and stand half a period
  a_rd_sel_lead: assert property ($fell(rd_sel_n) |=> $rose(k))
    else $error("read select not followed by k rise");
  a_wr_sel_stand: assert property ($fell(wr_sel_n) |-> (!wr_sel_n)[*4])
    else $error("write select shorter than half a period");
  // nothing moves on the pins at a capturing edge
  a_k_rise_setup: assert property ($rose(k) |-> $stable(sync_addr) && $stable(rd_sel_n)
    && $stable(wr_sel_n) && $stable(write_data_bus))
    else $error("pins changed at k rise");
  a_kn_rise_setup: assert property ($rose(k_n) |-> $stable(sync_addr)
    && $stable(write_data_bus) && $stable(byte_write_lane0_n))
    else $error("pins changed at k_n rise");
  // output clocks either follow the input pair or are both tied high
  a_c_follow_tie: assert property ((c && c_n) || (c == k && c_n == k_n))
    else $error("output clocks neither tied nor following k");
  // read data moves only together with an echo edge, and echoes keep running
  a_q_with_echo: assert property ($changed(read_data_bus) |->
    $changed(echo_clk_true) || $changed(echo_clk_comp))
    else $error("read data changed without an echo edge");
  a_echo_running: assert property ($changed(echo_clk_true) |-> ##[1:10] $changed(echo_clk_true))
    else $error("echo clock stopped");
endmodule : ddr_burst2_sram_port_assertions

// *** testbench/ddr_burst2_sram_port_tb.sv ***
`timescale 1ns/1ps
module ddr_burst2_sram_port_tb;
  import ddr_b2_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic wr_valid = 0, rd_valid = 0, out_clk_tie = 0, dll_bypass = 0;
  wr_req_t wr_req = '0;
  addr_t rd_addr = '0;
  logic wr_ready, rd_ready, rdata_valid, wr_commit;
  data_t rdata0, rdata1;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_commit = 0;
  int lat, lat_n, lat_b, lat_t, n;
  data_t mem_m [logic [`ADDR_W:0]];
  // ordinary cases: request in, read-back expected from the lane model
  wr_req_t rows [5] = '{'{18'h00010, 36'h123456789, 36'hABCDEF012, 4'h0, 4'h0},
    '{18'h00010, 36'hFFFFFFFFF, 36'h000000000, 4'h5, 4'hA},
    '{18'h3FFFF, 36'h0F0F0F0F0, 36'hF0F0F0F0F, 4'h0, 4'h0},
    '{18'h3FFFF, 36'h111111111, 36'h222222222, 4'hF, 4'hF},
    '{18'h3FFFF, 36'hAAAAAAAAA, 36'h555555555, 4'h6, 4'h9}};
  always #25 clk = ~clk;
  ddr_b2_link_if lnk ();
  wire lanes_t lanes_w = {lnk.byte_write_lane3_n, lnk.byte_write_lane2_n,
    lnk.byte_write_lane1_n, lnk.byte_write_lane0_n};
  ddr_burst2_ctrl ddr_burst2_ctrl_i (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_req(wr_req), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rdata_valid(rdata_valid), .rdata0(rdata0), .rdata1(rdata1),
    .out_clk_tie(out_clk_tie), .dll_bypass(dll_bypass), .link(lnk.ctrl));
  ddr_burst2_sram ddr_burst2_sram_i (.clk(clk), .rst_n(rst_n), .link(lnk.mem),
    .wr_commit(wr_commit));
  ddr_burst2_sram_port_assertions sva_i (.clk(clk), .rst_n(rst_n), .k(lnk.k),
    .k_n(lnk.k_n), .c(lnk.c), .c_n(lnk.c_n), .sync_addr(lnk.sync_addr),
    .rd_sel_n(lnk.rd_sel_n), .wr_sel_n(lnk.wr_sel_n),
    .byte_write_lane0_n(lnk.byte_write_lane0_n), .write_data_bus(lnk.write_data_bus),
    .read_data_bus(lnk.read_data_bus), .echo_clk_true(lnk.echo_clk_true),
    .echo_clk_comp(lnk.echo_clk_comp));
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // lane model: a high lane select keeps the old byte
  task automatic put(input addr_t a, input logic b, input data_t d, input lanes_t m);
    data_t w;
    w = mem_m.exists({a, b}) ? mem_m[{a, b}] : '0;
    for (int i = 0; i < `LANES; i++)
      if (!m[i]) w[i*`LANE_W +: `LANE_W] = d[i*`LANE_W +: `LANE_W];
    mem_m[{a, b}] = w;
  endtask : put
  // called at a falling edge; held until the edge that sees wr_ready high
  task automatic do_wr(input wr_req_t r);
    wr_valid = 1;
    wr_req = r;
    while (wr_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    wr_valid = 0;
    put(r.addr, 1'b0, r.d0, r.bw0_n);
    put(r.addr, 1'b1, r.d1, r.bw1_n);
  endtask : do_wr
  // latency counted from the k rise that carries the read command
  task automatic do_rd(input addr_t a, output int l);
    rd_valid = 1;
    rd_addr = a;
    while (rd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    rd_valid = 0;
    while (lnk.rd_sel_n !== 1'b0) @(negedge clk);
    @(posedge lnk.k);
    chk(lnk.sync_addr, a, "read address");
    l = 0;
    while (rdata_valid !== 1'b1) begin
      @(negedge clk);
      l++;
    end
    chk(rdata0, mem_m[{a, 1'b0}], "first beat");
    chk(rdata1, mem_m[{a, 1'b1}], "second beat");
  endtask : do_rd
  // watches the wire for one write burst
  task automatic wr_wire(input wr_req_t r);
    while (lnk.wr_sel_n !== 1'b0) @(negedge clk);
    @(posedge lnk.k);
    chk(lnk.write_data_bus, r.d0, "beat0 on wire");
    chk(lanes_w, r.bw0_n, "lanes beat0");
    @(posedge lnk.k_n);
    chk(lnk.sync_addr, r.addr, "write address");
    chk(lnk.write_data_bus, r.d1, "beat1 on wire");
    chk(lanes_w, r.bw1_n, "lanes beat1");
  endtask : wr_wire
  // retired buffer writes, counted while the pulse stands
  always @(negedge clk) begin
    if (wr_commit === 1'b1) n_commit++;
  end
  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      $display("FAIL %0t timeout", $time);
      test_done();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    foreach (rows[i]) begin
      fork
        do_wr(rows[i]);
        wr_wire(rows[i]);
      join
      @(negedge clk);
      do_rd(rows[i].addr, lat);
      $display("row %0d done", i);
    end
    chk(n_commit, 4, "buffered writes retired");
    do_rd(rows[0].addr, lat_n);
    dll_bypass = 1;
    repeat (8) @(negedge clk);
    do_rd(rows[0].addr, lat_b);
    chk(lat_n - lat_b, `K_HALF_CYC, "bypass latency");
    dll_bypass = 0;
    out_clk_tie = 1;
    repeat (8) @(negedge clk);
    chk({lnk.c, lnk.c_n}, 2'h3, "output clocks tied");
    do_rd(rows[0].addr, lat_t);
    chk(lat_t, lat_n, "tied latency");
    out_clk_tie = 0;
    $display("latency tests done");
    // a write and a read in flight together
    fork
      do_wr('{18'h00200, 36'h0DEADBEEF, 36'h987654321, 4'h0, 4'h0});
      do_rd(rows[2].addr, lat);
    join
    $display("concurrent test done");
    // fill the queue until it refuses, then let it drain
    n = 0;
    wr_valid = 1;
    while (wr_ready === 1'b1) begin
      wr_req = '{addr_t'(18'h00100 + n), data_t'(n), ~data_t'(n), 4'h0, 4'h0};
      put(wr_req.addr, 1'b0, wr_req.d0, 4'h0);
      put(wr_req.addr, 1'b1, wr_req.d1, 4'h0);
      @(negedge clk);
      n++;
    end
    wr_valid = 0;
    chk(n >= `FIFO_DEPTH && n <= `FIFO_DEPTH + 3, 1, "queue depth");
    repeat (24 * 8) @(negedge clk);
    chk(wr_ready, 1, "queue drained");
    do_rd(18'h00100, lat);
    do_rd(addr_t'(18'h00100 + n - 1), lat);
    $display("queue test done");
    // reset in mid-run brings the link back to idle
    rst_n = 0;
    repeat (8) @(negedge clk);
    chk({lnk.k, lnk.k_n, lnk.rd_sel_n, lnk.wr_sel_n}, 4'h7, "link idle in reset");
    chk({rd_ready, wr_ready}, 2'h3, "ready in reset");
    chk(rdata0, 0, "read data in reset");
    rst_n = 1;
    repeat (4) @(negedge clk);
    do_rd(rows[2].addr, lat);
    chk(lat, lat_n, "latency after reset");
    $display("reset test done");
    test_done();
  end
endmodule : ddr_burst2_sram_port_tb
